//--- rtl/descriptor_pkg.sv
// Constants of the transfer descriptor block.
// Assumes a 32-bit AHB-Lite register bus and byte-packed little-endian headers.
package descriptor_pkg;

  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0] HDR_LO_ADDR  = 8'h00;  // Header bytes 0..3
  localparam logic [7:0] HDR_HI_ADDR  = 8'h04;  // Header bytes 4..7
  localparam logic [7:0] CTRL_ADDR    = 8'h08;  // Start command
  localparam logic [7:0] STATUS_ADDR  = 8'h0C;  // Engine state
  localparam int         DEC_W        = 8;      // Decoded address bits

  // ==========================================================================
  // Header geometry and field positions (lower word = bytes 0..3)
  localparam int HDR_BYTES   = 8;
  localparam int LEN_W       = 10;
  localparam int XFER_LSB    = 0;   // Transferred length [9:0]
  localparam int TOGGLE_BIT  = 10;
  localparam int ACTIVE_BIT  = 11;
  localparam int CODE_LSB    = 12;  // Result code [15:12]
  localparam int LIMIT_LSB   = 16;  // Endpoint packet limit [25:16]
  localparam int SPEED_BIT   = 26;
  localparam int LAST_BIT    = 27;
  localparam int EP_LSB      = 28;  // Endpoint index [31:28]
  // Upper word = bytes 4..7
  localparam int REQ_LSB     = 0;   // Requested length [9:0]
  localparam int TOKEN_LSB   = 10;  // Token kind [11:10]
  localparam int OPF_BIT     = 13;  // One transaction per frame
  localparam int ADDR_LSB    = 16;  // Target device address [22:16]
  localparam int FORMAT_BIT  = 23;  // 1 = isochronous
  // Writable bits of the upper word; reserved bits read as zero
  localparam logic [31:0] HI_MASK = 32'h00FF_2FFF;

  // Control and status bits
  localparam int CTRL_START  = 0;
  localparam int ST_BUSY     = 0;
  localparam int ST_LISTEND  = 1;
  localparam int ST_FRAMEWT  = 2;

  // ==========================================================================
  // Result codes
  localparam logic [3:0] RC_CLEAN_FINISH     = 4'h0;
  localparam logic [3:0] RC_INVALID_PID_SEEN = 4'h7;
  localparam logic [3:0] RC_RECEIVED_TOO_MUCH= 4'h8;
  localparam logic [3:0] RC_SHORT_RECEPTION  = 4'h9;
  localparam logic [3:0] RC_MEMORY_WRITE_LAG = 4'hC;
  localparam logic [3:0] RC_MEMORY_READ_LAG  = 4'hD;

  // Token kinds
  typedef enum logic [1:0] {
    TOKEN_SETUP = 2'b00,
    TOKEN_OUT   = 2'b01,
    TOKEN_IN    = 2'b10,
    TOKEN_RSVD  = 2'b11
  } token_kind_e;

  // Engine states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT  = 2'b10,
    ST_HOLD  = 2'b11
  } engine_state_e;

  // AHB transfer types
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ    = 2'b11;

endpackage

//--- rtl/judge_if.sv
// Carries one finished transaction to the result judge and its verdict back.
// Assumes one clock domain; the path is combinational.
`timescale 1ns/1ps
interface judge_if;
  import descriptor_pkg::*;
  logic [LEN_W:0]   count;      // Bytes reported by the link, may overshoot
  logic [LEN_W-1:0] len_req;    // Bytes allowed in this packet
  logic [LEN_W-1:0] limit;      // Endpoint packet limit
  logic [LEN_W-1:0] remaining;  // Bytes still owed to the descriptor
  logic [1:0]       token;      // Token kind
  logic             iso;        // Isochronous format
  logic             pid_bad;    // Invalid packet identifier seen
  logic             wr_lag;     // Memory could not absorb IN data
  logic             rd_lag;     // Memory could not feed OUT data
  logic [3:0]       code;       // Verdict
  logic             final_xact; // Descriptor completes now
  logic [LEN_W-1:0] moved;      // Bytes credited to the descriptor
  modport judge (input count, len_req, limit, remaining, token, iso,
                 input pid_bad, wr_lag, rd_lag, output code, final_xact, moved);
  modport user  (output count, len_req, limit, remaining, token, iso,
                 output pid_bad, wr_lag, rd_lag, input code, final_xact, moved);
endinterface

//--- rtl/result_judge.sv
// Turns one transaction's outcome into a result code.
// Assumes the caller registers the verdict.
`timescale 1ns/1ps
module result_judge
  import descriptor_pkg::*;
(
  // Verdict channel
  judge_if.judge j
);

  // ==========================================================================
  // Verdict
  logic is_in;          // Reception direction
  logic over;           // More than allowed came back
  logic under;          // Short packet left the buffer unfilled

  assign is_in = (j.token == TOKEN_IN);
  assign over  = is_in && (j.count > {1'b0, j.len_req});
  assign under = is_in && (j.count < {1'b0, j.limit}) && (j.count < {1'b0, j.remaining});

  // Priority: identifier, memory lag, overshoot, short packet, then clean.
  // Reserved codes 1010 and 1011 have no branch, so they cannot appear.
  always_comb
  begin
    j.code       = RC_CLEAN_FINISH;
    j.final_xact = 1'b1;
    j.moved      = (j.count > {1'b0, j.len_req}) ? j.len_req : j.count[LEN_W-1:0];
    if (j.pid_bad)
    begin
      j.code = RC_INVALID_PID_SEEN;
    end
    else if (is_in && j.wr_lag)
    begin
      j.code = RC_MEMORY_WRITE_LAG;
    end
    else if (!is_in && j.rd_lag)
    begin
      j.code = RC_MEMORY_READ_LAG;
    end
    else if (over)
    begin
      j.code = RC_RECEIVED_TOO_MUCH;
    end
    else if (under && !j.iso)
    begin
      j.code = RC_SHORT_RECEPTION;
    end
    else if (!j.iso && (j.moved < j.remaining))
    begin
      j.final_xact = 1'b0;                       // More packets owed
    end
    else
    begin
      j.code = RC_CLEAN_FINISH;
    end
  end

endmodule // result_judge

//--- rtl/transfer_descriptor_fields.sv
// Transfer descriptor engine: runs one 8-byte header, writes back its result.
// Assumes a single-slave AHB-Lite bus and a link engine on the same clock.
//
// Notes on behaviour
// - Eight-byte header describes type, placement, size.
// - Write back bytes actually moved.
// - Code 0000 on clean finish.
// - Code 0111 on invalid packet identifier.
// - Code 1000 when endpoint returns too much.
// - Code 1001 on short unfilled reception; the code reports 0000 instead for isochronous headers.
// - Code 1100 when IN data outruns memory.
// - Code 1101 when memory starves OUT.
// - Run only active headers; clear active when done.
// - Toggle selects DATA0/DATA1, flips per data packet.
// - Packet never exceeds ten-bit endpoint limit.
// - Four-bit endpoint index selects endpoint.
// - List-end bit marks final descriptor.
// - Ten-bit length; multi-packet for bulk/control.
// - Per-frame option cleared at reset.
// - Per-frame option: one transaction each frame; the code applies it only when the format bit is clear.
// - Format bit picks isochronous handling.
// - Seven-bit target device address used.
//
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module transfer_descriptor_fields
  import descriptor_pkg::*;
#(
  parameter int ADDR_W = 32                  // AHB address width
)(
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // AHB-Lite slave
  input  wire logic              hsel_in,
  input  wire logic [ADDR_W-1:0] haddr_in,
  input  wire logic [1:0]        htrans_in,
  input  wire logic              hwrite_in,
  input  wire logic [2:0]        hsize_in,
  input  wire logic              hready_in,
  input  wire logic [31:0]       hwdata_in,
  output logic                   hreadyout_out,
  output logic                   hresp_out,
  output logic [31:0]            hrdata_out,
  // Transaction request to the link engine
  output logic                   xact_req_out,
  output logic [1:0]             xact_token_out,
  output logic [6:0]             xact_addr_out,
  output logic [3:0]             xact_ep_out,
  output logic                   xact_low_speed_out,
  output logic                   xact_toggle_out,
  output logic [LEN_W-1:0]       xact_len_out,
  output logic                   xact_iso_out,
  // Transaction outcome from the link engine
  input  wire logic              xact_done_in,
  input  wire logic [LEN_W:0]    xact_count_in,
  input  wire logic              xact_data_in,
  input  wire logic              xact_pid_bad_in,
  input  wire logic              xact_wr_lag_in,
  input  wire logic              xact_rd_lag_in,
  // Frame timing and list status
  input  wire logic              frame_tick_in,
  output logic                   busy_out,
  output logic                   list_end_out
);

  // ==========================================================================
  // Header storage and decoded fields
  logic [31:0]       hdr_lo;         // Bytes 0..3
  logic [31:0]       hdr_hi;         // Bytes 4..7
  engine_state_e     state;          // Engine state
  engine_state_e     next_state;     // Engine next state
  logic              frame_used;     // A transaction went out this frame
  logic              wr_pend;        // Write data phase follows
  logic [DEC_W-1:0]  wr_addr;        // Address of pending write
  logic [31:0]       next_rdata;     // Read mux
  logic              start_cmd;      // Start written this cycle
  logic [LEN_W-1:0]  xferred;        // Bytes moved so far
  logic [LEN_W-1:0]  limit;          // Endpoint packet limit
  logic [LEN_W-1:0]  requested;      // Requested length
  logic [LEN_W-1:0]  remaining;      // Bytes still owed
  logic [LEN_W-1:0]  next_len;       // Size of the next packet
  logic              active;         // Header may run
  logic              opf;            // One transaction per frame
  logic              iso;            // Isochronous format
  logic              addr_ok;        // Valid AHB address phase
  logic [DEC_W-1:0]  dec_addr;       // Decoded low address bits

  assign xferred   = hdr_lo[XFER_LSB +: LEN_W];
  assign limit     = hdr_lo[LIMIT_LSB +: LEN_W];
  assign requested = hdr_hi[REQ_LSB +: LEN_W];
  assign active    = hdr_lo[ACTIVE_BIT];
  assign opf       = hdr_hi[OPF_BIT];
  assign iso       = hdr_hi[FORMAT_BIT];
  assign remaining = (xferred < requested) ? (requested - xferred) : '0;
  // Requests above the limit split into limit-sized packets
  assign next_len  = (remaining > limit) ? limit : remaining;
  assign dec_addr  = haddr_in[DEC_W-1:0];
  assign addr_ok   = hsel_in && hready_in &&
                     ((htrans_in == HTRANS_NONSEQ) || (htrans_in == HTRANS_SEQ));
  assign start_cmd = wr_pend && (wr_addr == CTRL_ADDR) && hwdata_in[CTRL_START];

  // ==========================================================================
  // Result judge
  judge_if jdg ();
  assign jdg.count     = xact_count_in;
  assign jdg.len_req   = xact_len_out;
  assign jdg.limit     = limit;
  assign jdg.remaining = remaining;
  assign jdg.token     = hdr_hi[TOKEN_LSB +: 2];
  assign jdg.iso       = iso;
  assign jdg.pid_bad   = xact_pid_bad_in;
  assign jdg.wr_lag    = xact_wr_lag_in;
  assign jdg.rd_lag    = xact_rd_lag_in;
  result_judge u_judge (
    .j (jdg.judge)
  );

  // ==========================================================================
  // AHB-Lite slave: zero wait states, always OKAY
  // Registered so wait states can be added later without port changes
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end
    else
    begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end
  end
  // Capture a write address phase; the data arrives one cycle later
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end
    else
    begin
      wr_pend <= addr_ok && hwrite_in;
      wr_addr <= dec_addr;
    end
  end
  // Read mux; control and unmapped offsets read zero
  always_comb
  begin
    next_rdata = '0;
    if (dec_addr == HDR_LO_ADDR)
    begin
      next_rdata = hdr_lo;
    end
    else if (dec_addr == HDR_HI_ADDR)
    begin
      next_rdata = hdr_hi;
    end
    else if (dec_addr == STATUS_ADDR)
    begin
      next_rdata[ST_BUSY]    = busy_out;
      next_rdata[ST_LISTEND] = list_end_out;
      next_rdata[ST_FRAMEWT] = (state == ST_HOLD);
    end
  end
  // Read data is sampled in the address phase so it stands in the data phase
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      hrdata_out <= '0;
    end
    else if (addr_ok && !hwrite_in)
    begin
      hrdata_out <= next_rdata;
    end
  end

  // ==========================================================================
  // Lower header word: software writes while idle, hardware writes back
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      hdr_lo <= '0;
    end
    else if (state == ST_WAIT && xact_done_in)
    begin
      hdr_lo[XFER_LSB +: LEN_W] <= xferred + jdg.moved;
      hdr_lo[CODE_LSB +: 4]     <= jdg.code;
      if (xact_data_in)
      begin
        hdr_lo[TOGGLE_BIT] <= ~hdr_lo[TOGGLE_BIT];
      end
      if (jdg.final_xact)
      begin
        hdr_lo[ACTIVE_BIT] <= 1'b0;
      end
    end
    else if (wr_pend && wr_addr == HDR_LO_ADDR && state == ST_IDLE)
    begin
      hdr_lo <= hwdata_in;                  // Writes while busy are dropped
    end
  end
  // Upper header word, read-only to hardware; option bit clears at reset
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      hdr_hi <= '0;
    end
    else if (wr_pend && wr_addr == HDR_HI_ADDR && state == ST_IDLE)
    begin
      hdr_hi <= hwdata_in & HI_MASK;
    end
  end

  // ==========================================================================
  // Engine sequencing
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (start_cmd && active)                          // Inactive skipped
        begin
          next_state = (opf && !iso && frame_used) ? ST_HOLD : ST_ISSUE;
        end
      end
      ST_ISSUE: next_state = ST_WAIT;
      ST_WAIT:
      begin
        if (xact_done_in && jdg.final_xact)
        begin
          next_state = ST_IDLE;
        end
        else if (xact_done_in)
        begin
          next_state = (opf && !iso) ? ST_HOLD : ST_ISSUE;
        end
      end
      ST_HOLD: next_state = frame_tick_in ? ST_ISSUE : ST_HOLD;
      default: next_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state <= ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end
  // Frame budget: an issue in the tick cycle belongs to the new frame
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      frame_used <= 1'b0;
    end
    else if (state == ST_ISSUE)
    begin
      frame_used <= 1'b1;                                 // Set wins
    end
    else if (frame_tick_in)
    begin
      frame_used <= 1'b0;
    end
  end

  // ==========================================================================
  // Transaction request, one-cycle pulse with fields held until next issue
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      xact_req_out       <= 1'b0;
      xact_token_out     <= TOKEN_SETUP;
      xact_addr_out      <= '0;
      xact_ep_out        <= '0;
      xact_low_speed_out <= 1'b0;
      xact_toggle_out    <= 1'b0;
      xact_len_out       <= '0;
      xact_iso_out       <= 1'b0;
    end
    else
    begin
      xact_req_out <= (state == ST_ISSUE);
      if (state == ST_ISSUE)
      begin
        xact_token_out     <= hdr_hi[TOKEN_LSB +: 2];
        xact_addr_out      <= hdr_hi[ADDR_LSB +: 7];
        xact_ep_out        <= hdr_lo[EP_LSB +: 4];
        xact_low_speed_out <= hdr_lo[SPEED_BIT];
        xact_toggle_out    <= hdr_lo[TOGGLE_BIT];
        xact_len_out       <= next_len;
        xact_iso_out       <= iso;
      end
    end
  end

  // ==========================================================================
  // Status outputs
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      busy_out <= 1'b0;
    end
    else
    begin
      busy_out <= (next_state != ST_IDLE);
    end
  end
  // Raised when the final descriptor of a list completes, cleared by start
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      list_end_out <= 1'b0;
    end
    else if (state == ST_WAIT && xact_done_in && jdg.final_xact && hdr_lo[LAST_BIT])
    begin
      list_end_out <= 1'b1;
    end
    else if (start_cmd && state == ST_IDLE)
    begin
      list_end_out <= 1'b0;
    end
  end

endmodule // transfer_descriptor_fields

//--- testbench/transfer_descriptor_fields_monitor.sv
// Concurrent checks on the descriptor engine's ports.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module transfer_descriptor_fields_monitor
  import descriptor_pkg::*;
(
  // Clock and reset
  input wire logic             clk_in,
  input wire logic             rst_n_in,
  // Bus answer
  input wire logic             hreadyout_out,
  input wire logic             hresp_out,
  // Link side
  input wire logic             xact_req_out,
  input wire logic [1:0]       xact_token_out,
  input wire logic [6:0]       xact_addr_out,
  input wire logic [3:0]       xact_ep_out,
  input wire logic             xact_low_speed_out,
  input wire logic             xact_toggle_out,
  input wire logic [LEN_W-1:0] xact_len_out,
  input wire logic             xact_iso_out,
  input wire logic             xact_done_in,
  // Status
  input wire logic             busy_out,
  input wire logic             list_end_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================================================
  // Named steps
  sequence seq_quiet;
    !xact_req_out [*2];
  endsequence
  sequence seq_issue;
    ##[1:300] xact_req_out;
  endsequence
  // ==========================================================================
  // Checks
  a_bus_okay: assert property (hreadyout_out && !hresp_out)
    else $error("bus not okay");
  a_req_busy: assert property (xact_req_out |-> busy_out)
    else $error("request while idle");
  a_req_gap: assert property (xact_req_out |=> seq_quiet)
    else $error("requests too close");
  a_done_gap: assert property (xact_done_in |-> seq_quiet)
    else $error("request after done");
  a_start_issues: assert property ($rose(busy_out) |-> seq_issue)
    else $error("start without request");
  a_fields_held: assert property (!xact_req_out |-> $stable({xact_token_out,
    xact_addr_out, xact_ep_out, xact_low_speed_out, xact_toggle_out, xact_len_out, xact_iso_out}))
    else $error("fields moved");
  a_busy_done: assert property ($fell(busy_out) |-> $past(xact_done_in))
    else $error("busy fell early");
  a_listend_done: assert property ($rose(list_end_out) |-> $past(xact_done_in))
    else $error("list end early");
endmodule // transfer_descriptor_fields_monitor

bind transfer_descriptor_fields transfer_descriptor_fields_monitor mon (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out), .xact_req_out(xact_req_out), .xact_token_out(xact_token_out),
  .xact_addr_out(xact_addr_out), .xact_ep_out(xact_ep_out),
  .xact_low_speed_out(xact_low_speed_out), .xact_toggle_out(xact_toggle_out),
  .xact_len_out(xact_len_out), .xact_iso_out(xact_iso_out), .xact_done_in(xact_done_in),
  .busy_out(busy_out), .list_end_out(list_end_out));

//--- testbench/link_model.sv
// Behavioural link engine: answers each request after a set delay.
// Assumes the bench sets the outcome before each start.
`timescale 1ns/1ps
module link_model
  import descriptor_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // Request and scenario setup
  input  wire logic             req_in,
  input  wire logic [LEN_W-1:0] len_in,
  input  wire logic             full_in,
  input  wire logic [LEN_W:0]   cnt_in,
  input  wire logic [3:0]       dly_in,
  input  wire logic [2:0]       flags_in,
  input  wire logic             data_in,
  // Outcome
  output logic                  done_out,
  output logic [LEN_W:0]        count_out,
  output logic                  data_out,
  output logic [2:0]            flags_out
);
  logic       pend;  // Answer owed
  logic [3:0] wt;    // Cycles left
  // ==========================================================================
  // Outside a done pulse the outcome lines churn, so stale values never pass
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pend      <= 1'b0;
      wt        <= 4'h0;
      done_out  <= 1'b0;
      count_out <= '0;
      data_out  <= 1'b0;
      flags_out <= 3'h0;
    end
    else
    begin
      done_out  <= 1'b0;
      count_out <= ~count_out;
      data_out  <= ~data_out;
      flags_out <= ~flags_out;
      if (req_in)
      begin
        pend <= 1'b1;
        wt   <= dly_in;
      end
      else if (pend && wt <= 4'h1)
      begin
        // Full mode moves exactly what was allowed
        pend      <= 1'b0;
        done_out  <= 1'b1;
        count_out <= full_in ? {1'b0, len_in} : cnt_in;
        data_out  <= data_in;
        flags_out <= flags_in;
      end
      else if (pend)
        wt <= wt - 4'h1;
    end
  end
endmodule // link_model

//--- testbench/tb_top.sv
// Self-checking bench: programs headers over AHB-Lite, checks write-back.
// Assumes the link model answers every request.
`timescale 1ns/1ps
module tb_top;
  import descriptor_pkg::*;
  logic        clk_in = 0, rst_n_in = 0, hsel = 0, hwrite = 0, frame_tick = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0]  htrans = 0, s_tok;
  logic        hready, hresp, req, low, tog, iso_o, done, l_data, busy, lend;
  logic        full = 0, ldat = 0;
  logic [6:0]  addr_o, s_addr;
  logic [3:0]  ep_o, s_ep, ldly = 1;
  logic [9:0]  len_o;
  logic [10:0] cnt_o, lcnt = 0;
  logic [2:0]  lfl = 0, flg_o;
  logic [7:0]  rnd = 8'h60;        // LFSR seed
  logic        s_low, s_iso, s_tog; // Fields captured at the last request
  int          err_total = 0, num_checks = 0, nreq = 0, ndup = 0, fr = 0, fc = 0;

  transfer_descriptor_fields uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hready_in(hready), .hwdata_in(hwdata), .hreadyout_out(hready), .hresp_out(hresp),
    .hrdata_out(hrdata), .xact_req_out(req), .xact_token_out(s_tok), .xact_addr_out(addr_o),
    .xact_ep_out(ep_o), .xact_low_speed_out(low), .xact_toggle_out(tog), .xact_len_out(len_o),
    .xact_iso_out(iso_o), .xact_done_in(done), .xact_count_in(cnt_o), .xact_data_in(l_data),
    .xact_pid_bad_in(flg_o[0]), .xact_wr_lag_in(flg_o[1]), .xact_rd_lag_in(flg_o[2]),
    .frame_tick_in(frame_tick), .busy_out(busy), .list_end_out(lend));
  link_model lm (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req), .len_in(len_o),
    .full_in(full), .cnt_in(lcnt), .dly_in(ldly), .flags_in(lfl), .data_in(ldat),
    .done_out(done), .count_out(cnt_o), .data_out(l_data), .flags_out(flg_o));

  initial begin forever #2 clk_in = ~clk_in; end
  // Frame pulse every 64 cycles; tally requests and repeats per frame
  always @(posedge clk_in)
  begin
    fc <= fc + 1;
    frame_tick <= (fc % 64 == 63);
    if (frame_tick) fr <= 0;
    if (req)
    begin
      nreq <= nreq + 1;
      fr <= frame_tick ? 1 : fr + 1;
      if (fr > 0 && !frame_tick) ndup <= ndup + 1;
      s_addr <= addr_o;
      s_ep <= ep_o;
      s_low <= low;
      s_iso <= iso_o;
      s_tog <= tog;
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  // Expected outcome, packet by packet
  function automatic void predict(input logic [1:0] tk, input logic iso, input logic [9:0] lim,
    rq, input logic fl, input logic [10:0] cnt, input logic [2:0] fg, input logic dt,
    output logic [3:0] c, output logic [9:0] x, output logic f, output int n);
    logic [9:0] ln;
    logic [10:0] k;
    logic fin;
    x = 0; f = 0; n = 0; fin = 0;
    while (!fin)
    begin
      ln = (lim < rq - x) ? lim : rq - x;
      k = fl ? {1'b0, ln} : cnt;
      n++;
      f ^= dt;
      if (fg[0]) c = RC_INVALID_PID_SEEN;
      else if (tk == TOKEN_IN && fg[1]) c = RC_MEMORY_WRITE_LAG;
      else if (tk != TOKEN_IN && fg[2]) c = RC_MEMORY_READ_LAG;
      else if (tk == TOKEN_IN && k > ln) c = RC_RECEIVED_TOO_MUCH;
      else if (!iso && tk == TOKEN_IN && k < lim && k < rq - x) c = RC_SHORT_RECEPTION;
      else c = RC_CLEAN_FINISH;
      x += (k < ln) ? k[9:0] : ln;
      fin = iso || c != RC_CLEAN_FINISH || x >= rq;
    end
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One single AHB-Lite transfer
  task automatic ahb(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
    @(posedge clk_in);
    hsel <= 1; haddr <= a; htrans <= HTRANS_NONSEQ; hwrite <= wr;
    do @(posedge clk_in); while (hready !== 1'b1);
    hsel <= 0; htrans <= 2'b00; hwdata <= d;
    do @(posedge clk_in); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic run_case(input logic [1:0] tk, input logic iso, opf, input logic [9:0] lim,
    rq, input logic fl, input logic [10:0] cnt, input logic [2:0] fg);
    logic [31:0] lo, hi, q;
    logic [3:0] c;
    logic [9:0] x;
    logic f;
    int n, r0, d0, k;
    rnd = lfsr(rnd);
    lo = {rnd[3:0], rnd[4], rnd[5], lim, 4'h0, 1'b1, rnd[6], 10'h000};
    hi = {8'hFF, iso, rnd[7:1], 2'b11, opf, 1'b1, tk, rq};  // Reserved bits set
    predict(tk, iso, lim, rq, fl, cnt, fg, rnd[0], c, x, f, n);
    full <= fl; lcnt <= cnt; lfl <= fg; ldat <= rnd[0]; ldly <= {2'b00, rnd[2:1]} + 4'h1;
    ahb(1, HDR_LO_ADDR, lo, q);
    ahb(1, HDR_HI_ADDR, hi, q);
    r0 = nreq; d0 = ndup;
    ahb(1, CTRL_ADDR, 32'h1, q);
    repeat (2) @(posedge clk_in);
    check("busy", busy, 1'b1);
    k = 0;
    while (busy !== 1'b0 && k < 3000) begin @(posedge clk_in); k++; end
    ahb(0, HDR_LO_ADDR, 0, q);
    check("code", q[15:12], c);
    check("reserved code", q[15:13] === 3'b101, 0);
    check("moved", q[9:0], x);
    check("active", q[11], 0);
    check("toggle", q[10], lo[10] ^ f);
    check("last req toggle", s_tog, lo[10] ^ f ^ rnd[0]);
    check("fixed fields", q[31:16], lo[31:16]);
    check("requests", nreq - r0, n);
    if (opf) check("per frame", ndup - d0, 0);
    check("token", s_tok, tk);
    check("address", s_addr, hi[22:16]);
    check("endpoint", s_ep, lo[31:28]);
    check("speed", s_low, lo[26]);
    check("format", s_iso, iso);
    ahb(0, HDR_HI_ADDR, 0, q);
    check("upper", q, hi & HI_MASK);
    ahb(0, STATUS_ADDR, 0, q);
    check("list end", q[ST_LISTEND], lo[27]);
  endtask

  initial
  begin
    repeat (60000) @(posedge clk_in);
    err_total++;
    close_out();
  end
  // ==========================================================================
  // Main sequence
  initial
  begin
    logic [31:0] q;
    int r;
    logic [1:0] tk;
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1;
    ahb(0, HDR_HI_ADDR, 0, q);
    check("upper at reset", q, 0);
    ahb(0, 32'h10, 0, q);
    check("unmapped", q, 0);
    r = nreq;
    ahb(1, HDR_LO_ADDR, 0, q);
    ahb(1, CTRL_ADDR, 32'h1, q);
    repeat (4) @(posedge clk_in);
    check("inactive start", {busy, nreq - r}, 0);
    run_case(TOKEN_IN, 0, 0, 8, 20, 1, 0, 3'b000);
    run_case(TOKEN_IN, 0, 0, 8, 20, 0, 5, 3'b001);
    run_case(TOKEN_IN, 0, 0, 8, 20, 0, 12, 3'b000);
    run_case(TOKEN_IN, 0, 0, 8, 20, 0, 3, 3'b000);
    run_case(TOKEN_IN, 0, 0, 8, 20, 1, 0, 3'b010);
    run_case(TOKEN_OUT, 0, 0, 8, 20, 1, 0, 3'b100);
    run_case(TOKEN_SETUP, 0, 0, 8, 8, 1, 0, 3'b000);
    run_case(TOKEN_IN, 1, 0, 8, 20, 0, 3, 3'b000);
    run_case(TOKEN_OUT, 0, 1, 4, 12, 1, 0, 3'b000);
    run_case(TOKEN_IN, 0, 0, 10'h3FF, 10'h3FF, 1, 0, 3'b000);
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      tk = (rnd[1:0] == 2'b11) ? TOKEN_IN : rnd[1:0];
      run_case(tk, rnd[6] & rnd[0], 0, {6'h00, rnd[3:0]} + 10'h001, {4'h0, rnd[7:2]},
        tk != TOKEN_IN || rnd[4], {7'h00, rnd[7:4]}, (rnd[7:5] == 3'b111) ? rnd[2:0] : 3'b000);
    end
    close_out();
  end
endmodule // tb_top
